// ---- common/clk_pwr_pkg.sv ----
/*
 * Package for the clock distribution and power mode controller: register
 * byte offsets, field layouts, reset values, mode codes and carrier types.
 * Assumes a plain word-wide register port and a single 125 MHz clock.
 */
`default_nettype none
package clk_pwr_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int unsigned N_DIG = 8; // Digital dividers
	localparam int unsigned N_ANA = 4; // Analog dividers
	localparam int unsigned N_DIV = 12; // All dividers
	localparam int unsigned N_SRC = 7; // Clock sources
	localparam int unsigned N_SUB = 16; // Power-controlled subsystems
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFF_MODE = 8'h00; // Mode request / status
	localparam logic [7:0] OFF_ACT_TMPL = 8'h04; // Active template
	localparam logic [7:0] OFF_ALT_TMPL = 8'h08; // Alternate active template
	localparam logic [7:0] OFF_STATUS = 8'h0C; // Clock status
	localparam logic [7:0] OFF_USB_CFG = 8'h10; // USB doubler setup
	localparam logic [7:0] OFF_BUS_DIV = 8'h14; // Bus clock ratio
	localparam logic [7:0] OFF_DIV_BASE = 8'h40; // First divider, 4 bytes apart
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int unsigned SUB_CPU_BIT = 0; // Processor enable bit
	localparam int unsigned MODE_REQ_LSB = 0; // Mode request field
	localparam int unsigned MODE_CUR_LSB = 4; // Reported mode field
	localparam int unsigned MODE_BUSY_BIT = 8; // Transition in progress
	localparam int unsigned MODE_FORCE_BIT = 9; // Processor forced on
	localparam int unsigned STAT_SYS_LSB = 0; // Chosen system source
	localparam int unsigned STAT_LOCK_BIT = 4; // Doubler lock seen
	localparam logic [15:0] ACT_TMPL_RST = 16'hFFFF;
	localparam logic [15:0] ALT_TMPL_RST = 16'hFFFE;
	localparam logic [15:0] BUS_DIV_RST = 16'h0001;
	localparam logic [15:0] RATIO_MIN = 16'h0002;
	// ************************************************************
	// Source indices and USB source codes
	// ************************************************************
	localparam logic [2:0] SRC_MAIN_OSC = 3'h0; // main_internal_osc
	localparam logic [2:0] SRC_XTAL = 3'h1; // MHz crystal
	localparam logic [2:0] SRC_DOUBLER = 3'h2; // 48 MHz doubler
	localparam logic [2:0] SRC_FABRIC = 3'h3; // Routed fabric clock
	localparam logic [2:0] SRC_PLL = 3'h4; // PLL
	localparam logic [2:0] SRC_LOW_OSC = 3'h5; // low_speed_internal_osc
	localparam logic [2:0] SRC_WATCH = 3'h6; // watch_crystal_osc
	localparam logic [2:0] SRC_CHAIN = 3'h7; // Return from the fabric
	localparam logic [1:0] USB_FROM_OSC = 2'h0;
	localparam logic [1:0] USB_FROM_FABRIC = 2'h1;
	localparam logic [1:0] USB_FROM_XTAL = 2'h2;
	// ************************************************************
	// Mode codes and carriers
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'h0,
		MODE_ALT = 2'h1,
		MODE_SLEEP = 2'h2,
		MODE_HIB = 2'h3
	} pwr_mode_e;
	typedef struct packed {
		logic [1:0] skew; // Analog edge offset in clocks
		logic en; // Divider enable
		logic [2:0] sel; // Source select
		logic [15:0] ratio; // Division ratio
	} div_cfg_s;
	localparam int unsigned DIV_CFG_W = 22;
	typedef struct packed {
		logic pin; // pin_interrupt_unit event
		logic rtc; // Timekeeping tick
		logic timer; // central_periodic_timer
		logic low_voltage_detect; // low_voltage_detect
	} wake_s;
endpackage
`default_nettype wire

// ---- rtl/clk_pwr_ctrl.sv ----
/*
 * Clock distribution and power mode controller, all in one module.
 * Assumes source clocks arrive as one-cycle tick enables synchronous to
 * i_ref_clk, and that wake inputs and the register port are synchronous.
 */
// Added by the designer: the plain strobed port and the address map.
// Behaviour
// - Fastest available non-doubler source becomes system clock
// - Bus clock divided from i_ref_clk; processor follows
// - Eight digital 16-bit dividers, any source
// - Four analog dividers with edge skew
// - Eight-way source mux per divider
// - Ratios two and up, half duty
// - Resynchronised, glitch-free on setting changes
// - Fabric return input chains dividers
// - USB 48 MHz from doubled 24 MHz
// - USB status crosses into bus domain
// - Four modes: active, alternate, sleep, hibernate
// - Active mode follows active template
// - Alternate mode follows its own template
// - Sleep keeps only slow oscillators running
// - Sleep woken by pin, tick, timer, voltage
// - Hibernate stops clocks; pin wake only
// - Wake returns active, processor forced on
// - Reset lands in active mode
`timescale 1ns/1ps
`default_nettype none
module clk_pwr_ctrl (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Clock sources and fabric return
	input wire logic [6:0] i_src_tick,
	input wire logic [6:0] i_src_avail,
	input wire logic [11:0] i_fabric_ret,
	input wire logic i_usb_lock,
	// Wake events
	input wire clk_pwr_pkg::wake_s i_wake,
	// Clock outputs
	output logic [2:0] o_sysclk_sel,
	output logic o_bus_clk_en,
	output logic o_cpu_clk_en,
	output logic [7:0] o_dig_clk,
	output logic [3:0] o_ana_clk,
	output logic [1:0] o_usb_src_sel,
	output logic o_usb_dbl_en,
	// Power outputs
	output logic [15:0] o_subsys_en,
	output logic o_low_osc_en,
	output logic o_watch_xtal_en,
	output logic o_core_reg_en,
	output logic o_hib_reg_en,
	output clk_pwr_pkg::pwr_mode_e o_mode
);
	// ************************************************************
	// Helpers
	// ************************************************************
	// Ratios below two are raised to two
	function automatic logic [15:0] eff_ratio(input logic [15:0] r);
		eff_ratio = (r < clk_pwr_pkg::RATIO_MIN) ? clk_pwr_pkg::RATIO_MIN : r;
	endfunction
	// Eight-way mux: seven sources plus the fabric return
	function automatic logic src_pick(input logic [2:0] sel, input logic [6:0] ticks, input logic chain);
		src_pick = (sel == clk_pwr_pkg::SRC_CHAIN) ? chain : ticks[sel];
	endfunction

	// ************************************************************
	// Power mode state machine
	// ************************************************************
	typedef enum logic [5:0] {
		ST_ACTIVE = 6'h01,
		ST_ALT = 6'h02,
		ST_GATE_SLEEP = 6'h04,
		ST_SLEEP = 6'h08,
		ST_GATE_HIB = 6'h10,
		ST_HIB = 6'h20
	} pwr_state_e;
	pwr_state_e state_reg, state_next; // Controller state
	logic cpu_force_reg, cpu_force_next; // Processor held on after wake
	logic [15:0] act_tmpl_reg, act_tmpl_next; // Active template
	logic [15:0] alt_tmpl_reg, alt_tmpl_next; // Alternate template
	logic [15:0] sub_reg, sub_next; // Subsystem enables
	logic low_osc_reg, low_osc_next;
	logic watch_reg, watch_next;
	logic core_reg_reg, core_reg_next;
	clk_pwr_pkg::pwr_mode_e mode_reg, mode_next; // Reported mode
	logic run_reg, run_next; // Distribution clocks allowed
	logic wr_mode; // Mode request strobe
	logic [1:0] req; // Requested mode code

	assign wr_mode = i_wr && (i_addr == clk_pwr_pkg::OFF_MODE);
	assign req = i_wdata[clk_pwr_pkg::MODE_REQ_LSB +: 2];

	// Next state, template writes and power outputs
	always_comb begin
		state_next = state_reg;
		cpu_force_next = cpu_force_reg;
		act_tmpl_next = act_tmpl_reg;
		alt_tmpl_next = alt_tmpl_reg;
		if (i_wr && i_addr == clk_pwr_pkg::OFF_ACT_TMPL) begin
			act_tmpl_next = i_wdata[15:0];
			cpu_force_next = 1'b0; // Software takes back the processor bit
		end
		if (i_wr && i_addr == clk_pwr_pkg::OFF_ALT_TMPL) begin
			alt_tmpl_next = i_wdata[15:0];
		end
		case (state_reg)
			ST_ACTIVE, ST_ALT: begin
				// Request taken from either running mode; firmware checks supplies first
				if (wr_mode) begin
					case (req)
						clk_pwr_pkg::MODE_ACTIVE: state_next = ST_ACTIVE;
						clk_pwr_pkg::MODE_ALT: state_next = ST_ALT;
						clk_pwr_pkg::MODE_SLEEP: state_next = ST_GATE_SLEEP;
						default: state_next = ST_GATE_HIB;
					endcase
				end
			end
			ST_GATE_SLEEP: state_next = ST_SLEEP;
			ST_GATE_HIB: state_next = ST_HIB;
			ST_SLEEP: begin
				// Any of the four sleep wake sources
				if (i_wake.pin || i_wake.rtc || i_wake.timer || i_wake.low_voltage_detect) begin
					state_next = ST_ACTIVE;
					cpu_force_next = 1'b1;
				end
			end
			ST_HIB: begin
				// Only a pin event ends hibernate
				if (i_wake.pin) begin
					state_next = ST_ACTIVE;
					cpu_force_next = 1'b1;
				end
			end
			default: state_next = ST_ACTIVE;
		endcase
		// Outputs follow the next state, so gating leads the report
		sub_next = 16'h0000;
		low_osc_next = 1'b1;
		watch_next = 1'b1;
		core_reg_next = 1'b1;
		run_next = 1'b0;
		mode_next = clk_pwr_pkg::MODE_ACTIVE;
		case (state_next)
			ST_ACTIVE: begin
				sub_next = act_tmpl_next;
				sub_next[clk_pwr_pkg::SUB_CPU_BIT] = act_tmpl_next[clk_pwr_pkg::SUB_CPU_BIT] | cpu_force_next;
				run_next = 1'b1;
			end
			ST_ALT: begin
				sub_next = alt_tmpl_next;
				run_next = 1'b1;
				mode_next = clk_pwr_pkg::MODE_ALT;
			end
			ST_GATE_SLEEP: mode_next = mode_reg; // Still reports the old mode
			ST_SLEEP: mode_next = clk_pwr_pkg::MODE_SLEEP; // Only slow oscillators
			ST_GATE_HIB: begin
				mode_next = mode_reg;
				low_osc_next = 1'b0;
				watch_next = 1'b0;
				core_reg_next = 1'b0;
			end
			ST_HIB: begin
				mode_next = clk_pwr_pkg::MODE_HIB;
				low_osc_next = 1'b0;
				watch_next = 1'b0;
				core_reg_next = 1'b0;
			end
			default: mode_next = clk_pwr_pkg::MODE_ACTIVE;
		endcase
	end

	// Reset lands in active with full template
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_ACTIVE;
			cpu_force_reg <= 1'b0;
			act_tmpl_reg <= clk_pwr_pkg::ACT_TMPL_RST;
			alt_tmpl_reg <= clk_pwr_pkg::ALT_TMPL_RST;
			sub_reg <= clk_pwr_pkg::ACT_TMPL_RST;
			low_osc_reg <= 1'b1;
			watch_reg <= 1'b1;
			core_reg_reg <= 1'b1;
			run_reg <= 1'b1;
			mode_reg <= clk_pwr_pkg::MODE_ACTIVE;
		end else begin
			state_reg <= state_next;
			cpu_force_reg <= cpu_force_next;
			act_tmpl_reg <= act_tmpl_next;
			alt_tmpl_reg <= alt_tmpl_next;
			sub_reg <= sub_next;
			low_osc_reg <= low_osc_next;
			watch_reg <= watch_next;
			core_reg_reg <= core_reg_next;
			run_reg <= run_next;
			mode_reg <= mode_next;
		end
	end

	// ************************************************************
	// System clock choice, bus divider and USB setup
	// ************************************************************
	logic [2:0] sys_next; // Chosen system source
	logic [15:0] bus_div_reg, bus_div_next; // Bus ratio setting
	logic [15:0] bus_cnt_reg, bus_cnt_next;
	logic bus_en_reg, bus_en_next;
	logic cpu_en_reg, cpu_en_next;
	logic [1:0] usb_sel_reg, usb_sel_next;
	logic usb_en_reg, usb_en_next;
	logic lock_meta_reg, lock_sync_reg; // Two-stage lock synchroniser
	logic [2:0] sys_reg;

	// Fastest first; the doubler is kept for USB
	always_comb begin
		if (i_src_avail[clk_pwr_pkg::SRC_PLL]) sys_next = clk_pwr_pkg::SRC_PLL;
		else if (i_src_avail[clk_pwr_pkg::SRC_FABRIC]) sys_next = clk_pwr_pkg::SRC_FABRIC;
		else if (i_src_avail[clk_pwr_pkg::SRC_XTAL]) sys_next = clk_pwr_pkg::SRC_XTAL;
		else if (i_src_avail[clk_pwr_pkg::SRC_MAIN_OSC]) sys_next = clk_pwr_pkg::SRC_MAIN_OSC;
		else if (i_src_avail[clk_pwr_pkg::SRC_LOW_OSC]) sys_next = clk_pwr_pkg::SRC_LOW_OSC;
		else sys_next = clk_pwr_pkg::SRC_WATCH;
	end

	// Bus divider counts i_ref_clk cycles, not ticks of the chosen source
	always_comb begin
		bus_div_next = bus_div_reg;
		usb_sel_next = usb_sel_reg;
		usb_en_next = usb_en_reg & run_next; // Doubler off outside running modes
		if (i_wr && i_addr == clk_pwr_pkg::OFF_BUS_DIV) bus_div_next = i_wdata[15:0];
		if (i_wr && i_addr == clk_pwr_pkg::OFF_USB_CFG) begin
			usb_sel_next = i_wdata[1:0];
			usb_en_next = i_wdata[2] & run_next; // Never on in sleep or hibernate
		end
		bus_cnt_next = 16'h0000;
		bus_en_next = 1'b0;
		if (run_reg) begin
			if (bus_cnt_reg >= eff_ratio(bus_div_reg) - 16'h0001) begin
				bus_en_next = 1'b1;
			end else begin
				bus_cnt_next = bus_cnt_reg + 16'h0001;
			end
		end
		// Processor clock is the bus clock, gated by its enable
		cpu_en_next = bus_en_next & sub_reg[clk_pwr_pkg::SUB_CPU_BIT];
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sys_reg <= clk_pwr_pkg::SRC_MAIN_OSC;
			bus_div_reg <= clk_pwr_pkg::BUS_DIV_RST;
			bus_cnt_reg <= 16'h0000;
			bus_en_reg <= 1'b0;
			cpu_en_reg <= 1'b0;
			usb_sel_reg <= clk_pwr_pkg::USB_FROM_OSC;
			usb_en_reg <= 1'b0;
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			sys_reg <= sys_next;
			bus_div_reg <= bus_div_next;
			bus_cnt_reg <= bus_cnt_next;
			bus_en_reg <= bus_en_next;
			cpu_en_reg <= cpu_en_next;
			usb_sel_reg <= usb_sel_next;
			usb_en_reg <= usb_en_next;
			// USB side is asynchronous, so its lock is synchronised
			lock_meta_reg <= i_usb_lock;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// ************************************************************
	// Digital and analog dividers
	// ************************************************************
	clk_pwr_pkg::div_cfg_s cfg_reg [12], cfg_next [12]; // Software settings
	clk_pwr_pkg::div_cfg_s act_reg [12], act_next [12]; // Settings in use
	logic [15:0] cnt_reg [12], cnt_next [12];
	logic [11:0] lvl_reg, lvl_next; // Divided levels
	logic [11:0] ret_reg; // Previous fabric return levels
	logic [2:0] skw_reg [4], skw_next [4]; // Analog delay lines
	logic [3:0] ana_next;
	logic [3:0] ana_reg;

	always_comb begin
		for (int i = 0; i < 12; i++) begin
			logic tick;
			logic [15:0] half;
			tick = 1'b0;
			half = 16'h0000;
			cfg_next[i] = cfg_reg[i];
			act_next[i] = act_reg[i];
			cnt_next[i] = cnt_reg[i];
			lvl_next[i] = lvl_reg[i];
			if (i_wr && i_addr == clk_pwr_pkg::OFF_DIV_BASE + 8'(4 * i)) begin
				cfg_next[i] = i_wdata[clk_pwr_pkg::DIV_CFG_W-1:0];
			end
			// Rising edge of the fabric return chains dividers
			tick = src_pick(act_reg[i].sel, i_src_tick, i_fabric_ret[i] & ~ret_reg[i]);
			half = eff_ratio(act_reg[i].ratio) >> 1;
			if (!run_reg || !act_reg[i].en) begin
				// Stopped: output low, new setting taken at once
				cnt_next[i] = 16'h0000;
				lvl_next[i] = 1'b0;
				act_next[i] = cfg_reg[i];
			end else if (tick) begin
				if (cnt_reg[i] >= eff_ratio(act_reg[i].ratio) - 16'h0001) begin
					// Period end: new settings only here, so no runt
					cnt_next[i] = 16'h0000;
					lvl_next[i] = 1'b1;
					act_next[i] = cfg_reg[i];
				end else begin
					cnt_next[i] = cnt_reg[i] + 16'h0001;
					if (cnt_reg[i] + 16'h0001 == half) lvl_next[i] = 1'b0;
				end
			end
		end
		// Analog outputs shifted by skew clocks off digital edges
		for (int a = 0; a < 4; a++) begin
			skw_next[a] = {skw_reg[a][1:0], lvl_next[8 + a]};
			ana_next[a] = (act_reg[8 + a].skew == 2'h0) ? lvl_next[8 + a] : skw_reg[a][act_reg[8 + a].skew - 2'h1];
		end
	end

	// Levels are flopped on i_ref_clk, which resynchronises them
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 12; i++) begin
				cfg_reg[i] <= '0;
				act_reg[i] <= '0;
				cnt_reg[i] <= 16'h0000;
			end
			for (int a = 0; a < 4; a++) skw_reg[a] <= 3'h0;
			lvl_reg <= 12'h000;
			ret_reg <= 12'h000;
			ana_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 12; i++) begin
				cfg_reg[i] <= cfg_next[i];
				act_reg[i] <= act_next[i];
				cnt_reg[i] <= cnt_next[i];
			end
			for (int a = 0; a < 4; a++) skw_reg[a] <= skw_next[a];
			lvl_reg <= lvl_next;
			ret_reg <= i_fabric_ret;
			ana_reg <= ana_next;
		end
	end

	// ************************************************************
	// Register read-back
	// ************************************************************
	logic [31:0] rdata_reg, rdata_next;

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				clk_pwr_pkg::OFF_MODE: begin
					rdata_next[clk_pwr_pkg::MODE_CUR_LSB +: 2] = mode_reg;
					rdata_next[clk_pwr_pkg::MODE_BUSY_BIT] = (state_reg == ST_GATE_SLEEP) || (state_reg == ST_GATE_HIB);
					rdata_next[clk_pwr_pkg::MODE_FORCE_BIT] = cpu_force_reg;
				end
				clk_pwr_pkg::OFF_ACT_TMPL: rdata_next[15:0] = act_tmpl_reg;
				clk_pwr_pkg::OFF_ALT_TMPL: rdata_next[15:0] = alt_tmpl_reg;
				clk_pwr_pkg::OFF_STATUS: begin
					rdata_next[clk_pwr_pkg::STAT_SYS_LSB +: 3] = sys_reg;
					rdata_next[clk_pwr_pkg::STAT_LOCK_BIT] = lock_sync_reg;
				end
				clk_pwr_pkg::OFF_USB_CFG: rdata_next[2:0] = {usb_en_reg, usb_sel_reg};
				clk_pwr_pkg::OFF_BUS_DIV: rdata_next[15:0] = bus_div_reg;
				default: begin
					for (int i = 0; i < 12; i++) begin
						if (i_addr == clk_pwr_pkg::OFF_DIV_BASE + 8'(4 * i)) begin
							rdata_next[clk_pwr_pkg::DIV_CFG_W-1:0] = cfg_reg[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) rdata_reg <= 32'h0000_0000;
		else rdata_reg <= rdata_next;
	end

	// All outputs straight from flip-flops, except o_hib_reg_en, which is tied high
	assign o_rdata = rdata_reg;
	assign o_sysclk_sel = sys_reg;
	assign o_bus_clk_en = bus_en_reg;
	assign o_cpu_clk_en = cpu_en_reg;
	assign o_dig_clk = lvl_reg[7:0];
	assign o_ana_clk = ana_reg;
	assign o_usb_src_sel = usb_sel_reg;
	assign o_usb_dbl_en = usb_en_reg;
	assign o_subsys_en = sub_reg;
	assign o_low_osc_en = low_osc_reg;
	assign o_watch_xtal_en = watch_reg;
	assign o_core_reg_en = core_reg_reg;
	assign o_hib_reg_en = 1'b1;
	assign o_mode = mode_reg;
endmodule
`default_nettype wire

// ---- sim/clk_pwr_ctrl_sva.sv ----
/* Port checker for the clock and power controller.
   Assumes one clock domain and synchronous wake inputs. */
`timescale 1ns/1ps
`default_nettype none
module clk_pwr_ctrl_sva (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [6:0] i_src_avail,
	input wire clk_pwr_pkg::wake_s i_wake,
	input wire logic [2:0] o_sysclk_sel,
	input wire logic o_bus_clk_en,
	input wire logic o_cpu_clk_en,
	input wire logic o_usb_dbl_en,
	input wire logic [15:0] o_subsys_en,
	input wire logic o_low_osc_en,
	input wire logic o_watch_xtal_en,
	input wire logic o_core_reg_en,
	input wire logic o_hib_reg_en,
	input wire clk_pwr_pkg::pwr_mode_e o_mode
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	property p_boot; $rose(i_rst_n) |-> o_mode == clk_pwr_pkg::MODE_ACTIVE && o_subsys_en == 16'hFFFF; endproperty
	a_boot: assert property (p_boot) else $error("not active after reset");
	property p_sys; i_src_avail[4] [*2] |-> o_sysclk_sel == clk_pwr_pkg::SRC_PLL; endproperty
	a_sys: assert property (p_sys) else $error("fastest source not chosen");
	property p_cpu; o_cpu_clk_en |-> o_bus_clk_en; endproperty
	a_cpu: assert property (p_cpu) else $error("processor pulse without bus pulse");
	property p_gap; o_bus_clk_en |=> !o_bus_clk_en; endproperty
	a_gap: assert property (p_gap) else $error("bus ratio below two");
	property p_sleep; o_mode == clk_pwr_pkg::MODE_SLEEP |-> o_subsys_en == 16'h0000 && o_low_osc_en
		&& o_watch_xtal_en && !o_usb_dbl_en && !o_bus_clk_en; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep left resources on");
	property p_wake; o_mode == clk_pwr_pkg::MODE_SLEEP && i_wake != 4'h0
		|=> o_mode == clk_pwr_pkg::MODE_ACTIVE && o_subsys_en[0]; endproperty
	a_wake: assert property (p_wake) else $error("sleep wake failed");
	property p_hib; o_mode == clk_pwr_pkg::MODE_HIB |-> o_subsys_en == 16'h0000
		&& !(o_core_reg_en || o_low_osc_en || o_watch_xtal_en); endproperty
	a_hib: assert property (p_hib) else $error("hibernate left power on");
	property p_hold; o_mode == clk_pwr_pkg::MODE_HIB && !i_wake.pin |=> o_mode == clk_pwr_pkg::MODE_HIB; endproperty
	a_hold: assert property (p_hold) else $error("hibernate left without pin");
	property p_hreg; o_hib_reg_en; endproperty
	a_hreg: assert property (p_hreg) else $error("hibernate regulator off");
	property p_first; o_mode == clk_pwr_pkg::MODE_SLEEP && $past(o_mode) != clk_pwr_pkg::MODE_SLEEP
		|-> $past(o_subsys_en) == 16'h0000; endproperty
	a_first: assert property (p_first) else $error("mode reported before gating");
	c_sleep: cover property (o_mode == clk_pwr_pkg::MODE_SLEEP ##1 o_mode == clk_pwr_pkg::MODE_ACTIVE);
	c_hib: cover property (o_mode == clk_pwr_pkg::MODE_HIB ##1 o_mode == clk_pwr_pkg::MODE_ACTIVE);
	c_cpu: cover property (o_cpu_clk_en);
endmodule
bind clk_pwr_ctrl clk_pwr_ctrl_sva u_clk_pwr_ctrl_sva (.i_ref_clk, .i_rst_n, .i_src_avail, .i_wake,
	.o_sysclk_sel, .o_bus_clk_en, .o_cpu_clk_en, .o_usb_dbl_en, .o_subsys_en, .o_low_osc_en,
	.o_watch_xtal_en, .o_core_reg_en, .o_hib_reg_en, .o_mode);
`default_nettype wire

// ---- sim/clk_src_model.sv ----
/* Stand-in for oscillators, doubler and fabric routing.
   Assumes ticks are enables on the one reference clock. */
`timescale 1ns/1ps
`default_nettype none
module clk_src_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// From the controller
	input wire logic [7:0] i_dig_clk,
	input wire logic i_usb_dbl_en,
	// To the controller
	output logic [6:0] o_src_tick,
	output logic [11:0] o_fabric_ret,
	output logic o_usb_lock
);
	logic [2:0] cnt_reg [7]; // Per-source phase
	logic [3:0] lock_reg; // Doubler settle delay
	// Source k ticks every k+1 clocks, so each mux input differs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		for (int k = 0; k < 7; k++) begin
			if (!i_rst_n) cnt_reg[k] <= 3'h0;
			else cnt_reg[k] <= (cnt_reg[k] == 3'(k)) ? 3'h0 : cnt_reg[k] + 3'h1;
		end
		if (!i_rst_n) lock_reg <= 4'h0;
		else lock_reg <= {lock_reg[2:0], i_usb_dbl_en};
	end
	always_comb begin
		for (int k = 0; k < 7; k++) o_src_tick[k] = (cnt_reg[k] == 3'(k));
	end
	// Every return line carries divider 0, to chain it
	assign o_fabric_ret = {12{i_dig_clk[0]}};
	assign o_usb_lock = lock_reg[3];
endmodule
`default_nettype wire

// ---- sim/clock_tree_and_power_modes_test.sv ----
/* Self-checking bench for the clock and power controller.
   Assumes the source model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module clock_tree_and_power_modes_test;
	logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, rd_val;
	logic [6:0] i_src_avail = 7'h7F, i_src_tick;
	clk_pwr_pkg::wake_s i_wake = 4'h0;
	logic [11:0] i_fabric_ret;
	logic i_usb_lock, o_bus_clk_en, o_cpu_clk_en, o_usb_dbl_en, o_low_osc_en, o_watch_xtal_en, o_core_reg_en;
	logic o_hib_reg_en;
	logic [2:0] o_sysclk_sel;
	logic [7:0] o_dig_clk;
	logic [3:0] o_ana_clk;
	logic [1:0] o_usb_src_sel;
	logic [15:0] o_subsys_en;
	clk_pwr_pkg::pwr_mode_e o_mode;
	int bad_count = 0, total_checks = 0, per;
	logic [6:0] av [6] = '{7'h7F, 7'h6F, 7'h67, 7'h65, 7'h64, 7'h40}; // Doubler never wins
	logic [2:0] sx [6] = '{3'h4, 3'h3, 3'h1, 3'h0, 3'h5, 3'h6};
	wire [13:0] obs = {o_cpu_clk_en, o_bus_clk_en, o_ana_clk, o_dig_clk}; // Measured outputs
	always #4 i_ref_clk = ~i_ref_clk;
	clk_pwr_ctrl u_clk_pwr_ctrl (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_src_tick,
		.i_src_avail, .i_fabric_ret, .i_usb_lock, .i_wake, .o_sysclk_sel, .o_bus_clk_en, .o_cpu_clk_en,
		.o_dig_clk, .o_ana_clk, .o_usb_src_sel, .o_usb_dbl_en, .o_subsys_en, .o_low_osc_en,
		.o_watch_xtal_en, .o_core_reg_en, .o_hib_reg_en, .o_mode);
	clk_src_model u_clk_src_model (.i_ref_clk, .i_rst_n, .i_dig_clk(o_dig_clk), .i_usb_dbl_en(o_usb_dbl_en),
		.o_src_tick(i_src_tick), .o_fabric_ret(i_fabric_ret), .o_usb_lock(i_usb_lock));
	// ************************************************************
	// Bus, check and measurement tasks
	// ************************************************************
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask
	// Period between the 2nd and 3rd rise; 0 if none in the window
	task measure(input int idx);
		int t0, e;
		logic prev;
		per = 0;
		e = 0;
		t0 = 0;
		prev = obs[idx];
		for (int n = 0; n < 600 && e < 3; n++) begin
			@(posedge i_ref_clk);
			#1;
			if (obs[idx] && !prev) begin
				e++;
				if (e == 3) per = n - t0;
				t0 = n;
			end
			prev = obs[idx];
		end
	endtask
	task wait_mode(input clk_pwr_pkg::pwr_mode_e m);
		#1;
		for (int n = 0; n < 20; n++) begin
			if (o_mode === m) return;
			@(posedge i_ref_clk);
			#1;
		end
		chk("mode wait", m, o_mode);
		conclude;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		#1 chk("mode", clk_pwr_pkg::MODE_ACTIVE, o_mode);
		chk("subsys", 32'hFFFF, o_subsys_en);
		rd(clk_pwr_pkg::OFF_ACT_TMPL);
		chk("act tmpl", clk_pwr_pkg::ACT_TMPL_RST, rd_val);
		rd(clk_pwr_pkg::OFF_ALT_TMPL);
		chk("alt tmpl", clk_pwr_pkg::ALT_TMPL_RST, rd_val);
		rd(8'hFC);
		chk("unmapped", 32'h0, rd_val);
		measure(12);
		chk("bus period", 2, per);
		wr(clk_pwr_pkg::OFF_BUS_DIV, 32'h5);
		measure(12);
		chk("bus period", 5, per);
		measure(13);
		chk("cpu period", 5, per);
		wr(clk_pwr_pkg::OFF_ACT_TMPL, 32'hFFFE);
		measure(13);
		chk("cpu gated", 0, per);
		for (int k = 0; k < 6; k++) begin
			@(posedge i_ref_clk) i_src_avail <= av[k];
			repeat (3) @(posedge i_ref_clk);
			rd(clk_pwr_pkg::OFF_STATUS);
			chk("sys source", {29'h0, sx[k]}, {29'h0, rd_val[2:0]});
		end
		i_src_avail <= 7'h7F;
		for (int i = 0; i < 12; i++) begin
			if (i < 7) wr(8'(clk_pwr_pkg::OFF_DIV_BASE + 4 * i), {13'h1, 3'(i), 16'h4});
			else if (i == 7) wr(8'(clk_pwr_pkg::OFF_DIV_BASE + 28), {13'h1, 3'h7, 16'h2});
			else wr(8'(clk_pwr_pkg::OFF_DIV_BASE + 4 * i), {10'h0, 2'(i), 1'b1, 3'h0, 16'h1});
		end
		for (int i = 0; i < 12; i++) begin
			measure(i);
			chk("div period", (i < 7) ? 4 * (i + 1) : (i == 7) ? 8 : 2, per);
		end
		chk("ana skew", 32'hA, {28'h0, o_ana_clk ^ {4{o_ana_clk[0]}}});
		for (int s = 0; s < 3; s++) begin
			wr(clk_pwr_pkg::OFF_USB_CFG, 32'h4 | s);
			#1 chk("usb source", s, o_usb_src_sel);
		end
		repeat (8) @(posedge i_ref_clk);
		rd(clk_pwr_pkg::OFF_STATUS);
		chk("usb lock", 1, rd_val[4]);
		wr(clk_pwr_pkg::OFF_ACT_TMPL, 32'h1234);
		wr(clk_pwr_pkg::OFF_ALT_TMPL, 32'h5A5A);
		wr(clk_pwr_pkg::OFF_MODE, 32'h1);
		wait_mode(clk_pwr_pkg::MODE_ALT);
		chk("alt subsys", 32'h5A5A, o_subsys_en);
		wr(clk_pwr_pkg::OFF_MODE, 32'h0);
		wait_mode(clk_pwr_pkg::MODE_ACTIVE);
		chk("act subsys", 32'h1234, o_subsys_en);
		for (int w = 0; w < 4; w++) begin
			wr(clk_pwr_pkg::OFF_MODE, 32'h2);
			wait_mode(clk_pwr_pkg::MODE_SLEEP);
			chk("sleep osc", 1, o_low_osc_en & o_watch_xtal_en);
			rd(clk_pwr_pkg::OFF_MODE);
			chk("mode field", clk_pwr_pkg::MODE_SLEEP, rd_val[5:4]);
			wr(clk_pwr_pkg::OFF_MODE, 32'h0);
			repeat (3) @(posedge i_ref_clk);
			#1 chk("sleep kept", clk_pwr_pkg::MODE_SLEEP, o_mode);
			@(posedge i_ref_clk) i_wake <= 4'h1 << w;
			@(posedge i_ref_clk) i_wake <= 4'h0;
			wait_mode(clk_pwr_pkg::MODE_ACTIVE);
			chk("wake subsys", 32'h1235, o_subsys_en);
			rd(clk_pwr_pkg::OFF_MODE);
			chk("cpu forced", 1, rd_val[9]);
		end
		wr(clk_pwr_pkg::OFF_MODE, 32'h3);
		wait_mode(clk_pwr_pkg::MODE_HIB);
		chk("hib regs", 32'h1, {o_core_reg_en, o_watch_xtal_en, o_hib_reg_en});
		@(posedge i_ref_clk) i_wake <= 4'h7;
		@(posedge i_ref_clk) i_wake <= 4'h0;
		repeat (3) @(posedge i_ref_clk);
		#1 chk("hib kept", clk_pwr_pkg::MODE_HIB, o_mode);
		@(posedge i_ref_clk) i_wake <= 4'h8;
		@(posedge i_ref_clk) i_wake <= 4'h0;
		wait_mode(clk_pwr_pkg::MODE_ACTIVE);
		chk("hib wake subsys", 32'h1235, o_subsys_en);
		chk("hib wake regs", 32'h3, {o_core_reg_en, o_low_osc_en});
		conclude;
	end
endmodule
`default_nettype wire
